// ### cts_defs.vh
`ifndef CTS_DEFS_VH
`define CTS_DEFS_VH
// register byte offsets
`define CTS_REG_CTRL 8'h00
`define CTS_REG_START 8'h04
`define CTS_REG_INTERVAL 8'h08
`define CTS_REG_TIMING 8'h0C
`define CTS_REG_MASKS 8'h10
`define CTS_REG_STATUS 8'h14
`define CTS_REG_IRQ_STAT 8'h18
`define CTS_REG_IRQ_CLR 8'h1C
`define CTS_REG_IRQ_EN 8'h20
`define CTS_REG_TOUCHED 8'h24
`define CTS_REG_GROUPS 8'h28
`define CTS_REG_THRESH0 8'h40
`define CTS_REG_RESULT0 8'h80
// ctrl fields
`define CTS_CTRL_SRC 0
`define CTS_CTRL_BOTH 1
`define CTS_CTRL_LEVEL 2
// reset values
`define CTS_INTERVAL_RST 16'h0100
`define CTS_TIMING_RST 32'h0100_0404
`define CTS_THRESH_RST 16'h0000
`endif

// ### cts_touch_scan.v
// Contract
// - select=1: one sequence per software start request, no periodic starts.
// - select=0: sequences start periodically from the internal interval timer.
// - interval between timed starts is a programmable count of clock cycles.
// - sequencer keeps running timed scans while the system sleeps.
// - sequencer and counters run on the 8 MHz fast clock.
// - bias, pad power and start strobe come in sequence with programmable timing.
// - pad power and start strobe gated per pad by 10-bit work mask.
// - pulses per pad counted during interval; final count readable per pad.
// - all ten pad counters run in parallel in one sequence.
// - pad touched when its count is below that pad's threshold.
// - two 10-bit masks define wake group a and wake group b.
// - by default wakeup when any pad in group a is touched.
// - two-group mode: wakeup only when both groups have touched pads.
// - touch detection raises interrupt and a deep-sleep wake request.
// - one pulse per swing; touch judged on equal-length count intervals.
// - a setting selects the initial level of each pad's swing.
`timescale 1ns/1ps
`default_nettype none
`include "cts_defs.vh"
module cts_touch_scan #(
   parameter NPADS = 10,
   parameter CW = 16
) (
   // clock and reset (fast clock, nominally 8 MHz)
   input wire clk_in,
   input wire rstn_in,
   // avalon-mm slave
   input wire [7:0] avs_address_in,
   input wire avs_read_in,
   input wire avs_write_in,
   input wire [31:0] avs_writedata_in,
   input wire [3:0] avs_byteenable_in,
   output wire [31:0] avs_readdata_out,
   output wire avs_waitrequest_out,
   // analog front end
   input wire [NPADS-1:0] pad_pulse_out_in,
   output reg front_end_bias_enable_out,
   output reg [NPADS-1:0] pad_power_enable_out,
   output reg [NPADS-1:0] pad_start_out,
   output reg initial_level_select_out,
   // system
   output wire irq_out,
   output reg deep_sleep_wake_out
);
   localparam S_IDLE = 3'h0;
   localparam S_BIAS = 3'h1;
   localparam S_POWER = 3'h2;
   localparam S_START = 3'h3;
   localparam S_MEAS = 3'h4;
   localparam S_EVAL = 3'h5;

   reg start_source_select;
   reg wake_both_groups;
   reg [15:0] measure_interval_cycles;
   reg [31:0] timing;
   reg [NPADS-1:0] pad_work_mask;
   reg [NPADS-1:0] wake_group_a_mask;
   reg [NPADS-1:0] wake_group_b_mask;
   reg single_measure_request;
   reg [1:0] irq_stat;
   reg [1:0] irq_en;
   reg [NPADS-1:0] touched;
   reg [1:0] group_hit;
   reg [2:0] state;
   reg [15:0] step_cnt;
   reg [15:0] sleep_cnt;
   reg [31:0] rdata;
   reg rd_done;
   reg [NPADS*CW-1:0] thresh;
   reg [NPADS*CW-1:0] pad_count_result;
   reg [NPADS*CW-1:0] run_cnt;
   reg [NPADS-1:0] sy1;
   reg [NPADS-1:0] sy2;
   reg [NPADS-1:0] sy3;
   wire [NPADS-1:0] next_touched;
   reg [31:0] next_rdata;
   reg seq_done;
   reg wake_event;
   integer i;
   integer j;

   wire wr = avs_write_in;
   wire [7:0] bias_time = timing[7:0];
   wire [7:0] power_time = timing[15:8];
   wire [15:0] meas_time = timing[31:16];
   wire step_end = (step_cnt == 16'h0000);
   // a timed start only fires from idle; a wrap during a scan is dropped, not held
   wire timer_start = ~start_source_select & (sleep_cnt == 16'h0000);
   wire go = (state == S_IDLE) & (start_source_select ? single_measure_request : timer_start);
   wire [NPADS-1:0] pulse_rise = sy2 & ~sy3;

   assign avs_waitrequest_out = avs_read_in & ~rd_done;
   assign avs_readdata_out = rdata;
   assign irq_out = |(irq_stat & irq_en);

   // pad pulses cross from the analog side through three flops
   always @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         sy1 <= {NPADS{1'b0}};
         sy2 <= {NPADS{1'b0}};
         sy3 <= {NPADS{1'b0}};
      end
      else
      begin
         sy1 <= pad_pulse_out_in;
         sy2 <= sy1;
         sy3 <= sy2;
      end
   end

   always @*
   begin
      wake_event = 1'b0;
      if (seq_done)
      begin
         if (wake_both_groups)
         begin
            wake_event = (|(next_touched & wake_group_a_mask)) & (|(next_touched & wake_group_b_mask));
         end
         else
         begin
            wake_event = |(next_touched & wake_group_a_mask);
         end
      end
   end

   // sequencer: one clock domain, no sleep gating, so it keeps scanning in sleep
   always @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         state <= S_IDLE;
         step_cnt <= 16'h0000;
         sleep_cnt <= `CTS_INTERVAL_RST;
         front_end_bias_enable_out <= 1'b0;
         pad_power_enable_out <= {NPADS{1'b0}};
         pad_start_out <= {NPADS{1'b0}};
         seq_done <= 1'b0;
      end
      else
      begin
         seq_done <= 1'b0;
         if (start_source_select | (sleep_cnt == 16'h0000))
         begin
            sleep_cnt <= measure_interval_cycles;
         end
         else
         begin
            sleep_cnt <= sleep_cnt - 16'h0001;
         end
         if (!step_end)
         begin
            step_cnt <= step_cnt - 16'h0001;
         end
         case (state)
            S_IDLE:
            begin
               if (go)
               begin
                  state <= S_BIAS;
                  front_end_bias_enable_out <= 1'b1;
                  step_cnt <= {8'h00, bias_time};
               end
            end
            S_BIAS:
            begin
               if (step_end)
               begin
                  state <= S_POWER;
                  pad_power_enable_out <= pad_work_mask;
                  step_cnt <= {8'h00, power_time};
               end
            end
            S_POWER:
            begin
               if (step_end)
               begin
                  state <= S_START;
                  pad_start_out <= pad_work_mask;
               end
            end
            S_START:
            begin
               pad_start_out <= {NPADS{1'b0}};
               state <= S_MEAS;
               // same window length every scan keeps counts comparable
               step_cnt <= meas_time;
            end
            S_MEAS:
            begin
               if (step_end)
               begin
                  state <= S_EVAL;
                  pad_power_enable_out <= {NPADS{1'b0}};
                  front_end_bias_enable_out <= 1'b0;
                  seq_done <= 1'b1;
               end
            end
            S_EVAL:
            begin
               state <= S_IDLE;
            end
            default:
            begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   // ten counters in parallel; pulses count only while measuring
   genvar g;
   generate
      for (g = 0; g < NPADS; g = g + 1)
      begin : pads
         assign next_touched[g] = pad_work_mask[g] & (run_cnt[g*CW +: CW] < thresh[g*CW +: CW]);
         always @(posedge clk_in)
         begin
            if (!rstn_in)
            begin
               run_cnt[g*CW +: CW] <= {CW{1'b0}};
            end
            else if (state == S_START)
            begin
               run_cnt[g*CW +: CW] <= {CW{1'b0}};
            end
            else if ((state == S_MEAS) && pad_work_mask[g] && pulse_rise[g] && ~&run_cnt[g*CW +: CW])
            begin
               run_cnt[g*CW +: CW] <= run_cnt[g*CW +: CW] + 1'b1;
            end
         end
      end
   endgenerate

   // results and interrupt
   always @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         pad_count_result <= {NPADS*CW{1'b0}};
         touched <= {NPADS{1'b0}};
         group_hit <= 2'b00;
         irq_stat <= 2'b00;
         deep_sleep_wake_out <= 1'b0;
      end
      else
      begin
         if (seq_done)
         begin
            pad_count_result <= run_cnt;
            touched <= next_touched;
            group_hit <= {|(next_touched & wake_group_b_mask), |(next_touched & wake_group_a_mask)};
         end
         // set beats clear in the same cycle
         if (wr && avs_address_in == `CTS_REG_IRQ_CLR && avs_byteenable_in[0])
         begin
            irq_stat <= (irq_stat & ~avs_writedata_in[1:0]) | {seq_done, wake_event};
            deep_sleep_wake_out <= (deep_sleep_wake_out & ~avs_writedata_in[0]) | wake_event;
         end
         else
         begin
            irq_stat <= irq_stat | {seq_done, wake_event};
            deep_sleep_wake_out <= deep_sleep_wake_out | wake_event;
         end
      end
   end

   // register writes
   always @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         start_source_select <= 1'b0;
         wake_both_groups <= 1'b0;
         initial_level_select_out <= 1'b0;
         measure_interval_cycles <= `CTS_INTERVAL_RST;
         timing <= `CTS_TIMING_RST;
         pad_work_mask <= {NPADS{1'b0}};
         wake_group_a_mask <= {NPADS{1'b0}};
         wake_group_b_mask <= {NPADS{1'b0}};
         single_measure_request <= 1'b0;
         irq_en <= 2'b00;
         thresh <= {NPADS*CW{1'b0}};
      end
      else
      begin
         if (go)
         begin
            single_measure_request <= 1'b0;
         end
         if (wr)
         begin
            case (avs_address_in)
               `CTS_REG_CTRL:
               begin
                  if (avs_byteenable_in[0])
                  begin
                     start_source_select <= avs_writedata_in[`CTS_CTRL_SRC];
                     wake_both_groups <= avs_writedata_in[`CTS_CTRL_BOTH];
                     initial_level_select_out <= avs_writedata_in[`CTS_CTRL_LEVEL];
                  end
               end
               `CTS_REG_START:
               begin
                  if (avs_byteenable_in[0] && avs_writedata_in[0])
                  begin
                     single_measure_request <= 1'b1;
                  end
               end
               `CTS_REG_INTERVAL:
               begin
                  measure_interval_cycles <= avs_writedata_in[15:0];
               end
               `CTS_REG_TIMING:
               begin
                  timing <= avs_writedata_in;
               end
               `CTS_REG_MASKS:
               begin
                  pad_work_mask <= avs_writedata_in[9:0];
                  wake_group_a_mask <= avs_writedata_in[19:10];
                  wake_group_b_mask <= avs_writedata_in[29:20];
               end
               `CTS_REG_IRQ_EN:
               begin
                  irq_en <= avs_writedata_in[1:0];
               end
               default:
               begin
                  for (i = 0; i < NPADS; i = i + 1)
                  begin
                     if (avs_address_in == `CTS_REG_THRESH0 + 4 * i)
                     begin
                        thresh[i*CW +: CW] <= avs_writedata_in[CW-1:0];
                     end
                  end
               end
            endcase
         end
      end
   end

   // reads answer one cycle after request
   always @*
   begin
      next_rdata = 32'h0000_0000;
      case (avs_address_in)
         `CTS_REG_CTRL: next_rdata = {29'h0, initial_level_select_out, wake_both_groups, start_source_select};
         `CTS_REG_START: next_rdata = {31'h0, single_measure_request};
         `CTS_REG_INTERVAL: next_rdata = {16'h0, measure_interval_cycles};
         `CTS_REG_TIMING: next_rdata = timing;
         `CTS_REG_MASKS: next_rdata = {2'b00, wake_group_b_mask, wake_group_a_mask, pad_work_mask};
         `CTS_REG_STATUS: next_rdata = {28'h0, (state != S_IDLE), state};
         `CTS_REG_IRQ_STAT: next_rdata = {30'h0, irq_stat};
         `CTS_REG_IRQ_EN: next_rdata = {30'h0, irq_en};
         `CTS_REG_TOUCHED: next_rdata = {22'h0, touched};
         `CTS_REG_GROUPS: next_rdata = {30'h0, group_hit};
         default:
         begin
            for (j = 0; j < NPADS; j = j + 1)
            begin
               if (avs_address_in == `CTS_REG_THRESH0 + 4 * j)
               begin
                  next_rdata = {16'h0, thresh[j*CW +: CW]};
               end
               if (avs_address_in == `CTS_REG_RESULT0 + 4 * j)
               begin
                  next_rdata = {16'h0, pad_count_result[j*CW +: CW]};
               end
            end
         end
      endcase
   end

   always @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         rdata <= 32'h0000_0000;
         rd_done <= 1'b0;
      end
      else
      begin
         rd_done <= avs_read_in & ~rd_done;
         if (avs_read_in & ~rd_done)
         begin
            rdata <= next_rdata;
         end
      end
   end
endmodule
`default_nettype wire

// ### cts_touch_scan_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "cts_defs.vh"
module cts_touch_scan_asserts #(
   parameter NPADS = 10
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // register bus
   input wire logic [7:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   // front end and system
   input wire logic [NPADS-1:0] pad_pulse_out_in,
   input wire logic front_end_bias_enable_out,
   input wire logic [NPADS-1:0] pad_power_enable_out,
   input wire logic [NPADS-1:0] pad_start_out,
   input wire logic initial_level_select_out,
   input wire logic irq_out,
   input wire logic deep_sleep_wake_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   wire clr_wake = avs_write_in && avs_address_in == `CTS_REG_IRQ_CLR && avs_byteenable_in[0] && avs_writedata_in[0];
   sequence s_bias_up;
      $rose(front_end_bias_enable_out);
   endsequence
   sequence s_power_up;
      ##[1:260] $rose(|pad_power_enable_out);
   endsequence
   a_bias_leads_power: assert property (s_bias_up |-> s_power_up)
      else $error("pad power did not follow bias");
   a_power_needs_bias: assert property (|pad_power_enable_out |-> front_end_bias_enable_out)
      else $error("pad power without bias");
   a_start_in_power: assert property ((pad_start_out & ~pad_power_enable_out) == '0)
      else $error("start strobe on unpowered pad");
   a_start_one_cycle: assert property (|pad_start_out |=> pad_start_out == '0)
      else $error("start strobe longer than one cycle");
   a_start_full_mask: assert property (|pad_start_out |-> pad_start_out == pad_power_enable_out)
      else $error("start strobe differs from powered pads");
   a_wake_sticky: assert property (deep_sleep_wake_out && !clr_wake |=> deep_sleep_wake_out)
      else $error("wake flag dropped without clear");
   // bias drops at the edge that opens the evaluation cycle, one cycle before the wake flag rises
   a_wake_after_measure: assert property ($rose(deep_sleep_wake_out) |-> $past(front_end_bias_enable_out, 2))
      else $error("wake raised outside sequence end");
   a_write_no_wait: assert property (avs_write_in |-> !avs_waitrequest_out)
      else $error("write stalled");
   a_read_one_wait: assert property (avs_read_in && avs_waitrequest_out |=> !avs_waitrequest_out)
      else $error("read wait longer than one cycle");
endmodule
bind cts_touch_scan cts_touch_scan_asserts #(.NPADS(NPADS)) cts_touch_scan_asserts_i (
   .clk_in(clk_in),
   .rstn_in(rstn_in),
   .avs_address_in(avs_address_in),
   .avs_read_in(avs_read_in),
   .avs_write_in(avs_write_in),
   .avs_writedata_in(avs_writedata_in),
   .avs_byteenable_in(avs_byteenable_in),
   .avs_readdata_out(avs_readdata_out),
   .avs_waitrequest_out(avs_waitrequest_out),
   .pad_pulse_out_in(pad_pulse_out_in),
   .front_end_bias_enable_out(front_end_bias_enable_out),
   .pad_power_enable_out(pad_power_enable_out),
   .pad_start_out(pad_start_out),
   .initial_level_select_out(initial_level_select_out),
   .irq_out(irq_out),
   .deep_sleep_wake_out(deep_sleep_wake_out)
);
`default_nettype wire

// ### cts_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
module cts_pad_model (
   // clock
   input wire logic clk_in,
   // pad controls
   input wire logic [9:0] power_in,
   input wire logic [9:0] touch_in,
   // swing pulses
   output logic [9:0] pulse_out
);
   logic [3:0] phase = 4'h0;
   always @(posedge clk_in)
   begin
      phase <= phase + 4'h1;
   end
   // touched pad swings four times slower; unpowered pad rests low
   always_comb
   begin
      for (int p = 0; p < 10; p++)
         pulse_out[p] = power_in[p] & (touch_in[p] ? phase[3] : phase[1]);
   end
endmodule
`default_nettype wire

// ### tb_cts_touch_scan.sv
`timescale 1ns/1ps
`default_nettype none
`include "cts_defs.vh"
module tb_cts_touch_scan;
   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic [7:0] avs_address_in = 8'h00;
   logic avs_read_in = 1'b0;
   logic avs_write_in = 1'b0;
   logic [31:0] avs_writedata_in = 32'h0000_0000;
   logic [3:0] avs_byteenable_in = 4'hF;
   wire [31:0] avs_readdata_out;
   wire avs_waitrequest_out;
   wire [9:0] pad_pulse_out_in;
   wire front_end_bias_enable_out;
   wire [9:0] pad_power_enable_out;
   wire [9:0] pad_start_out;
   wire initial_level_select_out;
   wire irq_out;
   wire deep_sleep_wake_out;
   logic [9:0] touch = 10'h000;
   logic [31:0] q;
   logic bias_d = 1'b0;
   logic [9:0] start_seen = 10'h000;
   int bias_rises = 0;
   int cycles = 0;
   int err_count = 0;
   int check_count = 0;
   int n0;
   cts_touch_scan cts_touch_scan_i (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .avs_address_in(avs_address_in),
      .avs_read_in(avs_read_in),
      .avs_write_in(avs_write_in),
      .avs_writedata_in(avs_writedata_in),
      .avs_byteenable_in(avs_byteenable_in),
      .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out),
      .pad_pulse_out_in(pad_pulse_out_in),
      .front_end_bias_enable_out(front_end_bias_enable_out),
      .pad_power_enable_out(pad_power_enable_out),
      .pad_start_out(pad_start_out),
      .initial_level_select_out(initial_level_select_out),
      .irq_out(irq_out),
      .deep_sleep_wake_out(deep_sleep_wake_out)
   );
   cts_pad_model cts_pad_model_i (.clk_in(clk_in), .power_in(pad_power_enable_out), .touch_in(touch),
      .pulse_out(pad_pulse_out_in));
   initial
   begin
      forever #4 clk_in = ~clk_in;
   end
   // hang guard: the whole run needs about 2000 cycles
   always @(posedge clk_in)
   begin
      cycles <= cycles + 1;
      bias_d <= front_end_bias_enable_out;
      start_seen <= start_seen | pad_start_out;
      if (front_end_bias_enable_out && !bias_d)
         bias_rises <= bias_rises + 1;
      if (cycles == 30000)
      begin
         err_count++;
         complete_run();
      end
   end
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // the edge before raising keeps a release and a new request apart
   task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk_in);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_read_in <= rd;
      avs_write_in <= !rd;
      @(posedge clk_in);
      while (avs_waitrequest_out)
         @(posedge clk_in);
      r = avs_readdata_out;
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
   endtask
   task automatic scan(input logic [9:0] t);
      touch <= t;
      bus(0, `CTS_REG_START, 32'h1, q);
      q = 32'h0;
      for (int k = 0; k < 100 && q[1] !== 1'b1; k++)
         bus(1, `CTS_REG_IRQ_STAT, 32'h0, q);
      check("done", q[1], 1'b1);
      bus(0, `CTS_REG_IRQ_CLR, 32'h2, q);
      @(negedge clk_in);
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (5) @(posedge clk_in);
      rstn_in <= 1'b1;
      bus(1, `CTS_REG_INTERVAL, 32'h0, q);
      check("interval", q, {16'h0000, `CTS_INTERVAL_RST});
      bus(1, `CTS_REG_TIMING, 32'h0, q);
      check("timing", q, `CTS_TIMING_RST);
      bus(1, 8'h3C, 32'h0, q);
      check("unmapped", q, 32'h0);
      bus(0, `CTS_REG_TIMING, 32'h0040_0101, q);
      for (int i = 0; i < 10; i++)
         bus(0, 8'(`CTS_REG_THRESH0 + 4 * i), 32'hA, q);
      bus(0, `CTS_REG_MASKS, {2'b00, 10'h010, 10'h003, 10'h2FF}, q);
      bus(0, `CTS_REG_IRQ_EN, 32'h1, q);
      bus(0, `CTS_REG_CTRL, 32'h5, q);
      n0 = bias_rises;
      scan(10'h112);
      bus(1, `CTS_REG_TOUCHED, 32'h0, q);
      check("touched", q, 32'h012);
      bus(1, `CTS_REG_GROUPS, 32'h0, q);
      check("groups", q, 32'h3);
      bus(1, `CTS_REG_RESULT0, 32'h0, q);
      check("untouched count", 32'(q >= 32'hA), 32'h1);
      bus(1, 8'(`CTS_REG_RESULT0 + 4), 32'h0, q);
      check("touched count", 32'(q < 32'hA), 32'h1);
      bus(1, 8'(`CTS_REG_RESULT0 + 32), 32'h0, q);
      check("masked count", q, 32'h0);
      check("irq", irq_out, 1'b1);
      check("wake", deep_sleep_wake_out, 1'b1);
      check("level", initial_level_select_out, 1'b1);
      check("start mask", start_seen, 32'h2FF);
      repeat (600) @(posedge clk_in);
      check("one start", bias_rises - n0, 1);
      bus(0, `CTS_REG_IRQ_CLR, 32'h3, q);
      @(negedge clk_in);
      check("irq cleared", irq_out, 1'b0);
      check("wake cleared", deep_sleep_wake_out, 1'b0);
      bus(0, `CTS_REG_CTRL, 32'h3, q);
      scan(10'h002);
      bus(1, `CTS_REG_IRQ_STAT, 32'h0, q);
      check("one group", q[0], 1'b0);
      scan(10'h012);
      check("both groups", irq_out, 1'b1);
      bus(0, `CTS_REG_IRQ_EN, 32'h0, q);
      @(negedge clk_in);
      check("irq masked", irq_out, 1'b0);
      bus(0, `CTS_REG_IRQ_CLR, 32'h3, q);
      // 200-cycle period: starts land 200, 400, 600 and 800 cycles after the mode switch
      bus(0, `CTS_REG_INTERVAL, 32'h0000_00C7, q);
      bus(0, `CTS_REG_CTRL, 32'h0, q);
      n0 = bias_rises;
      repeat (1000) @(posedge clk_in);
      check("timed starts", bias_rises - n0, 32'h4);
      bus(0, `CTS_REG_CTRL, 32'h1, q);
      complete_run();
   end
endmodule
`default_nettype wire
